/* tb/i2css_assertions.sv */
// Port-level checks for the I2C slave status flag block.
`include "i2css_consts.vh"
// ==========================================================================
// Checker
module i2css_assertions #(
   parameter ADDR_W = 18
) (
   input wire i_clock,
   input wire i_rst_b,
   input wire [ADDR_W-1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire i_scl,
   input wire o_sda_oe_b,
   input wire o_wake,
   input wire o_irq
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);
   wire [15:0] idx = i_avs_address[ADDR_W-1:2];
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_idle_rdata: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
      else $error("read data outside answer");
   a_status_bits: assert property (i_avs_read && !o_avs_waitrequest && idx == `I2CSS_IDX_STATUS
      |-> (o_avs_readdata & ~32'h00003f1e) == 32'h0) else $error("reserved status bit set");
   a_clear_wo: assert property (i_avs_read && !o_avs_waitrequest && idx == `I2CSS_IDX_CLEAR
      |-> o_avs_readdata == 32'h0) else $error("clear register readable");
   a_reset_idle: assert property ($rose(i_rst_b)
      |-> o_avs_waitrequest && o_sda_oe_b && !o_irq && !o_wake) else $error("reset state");
   a_drive_scl_low: assert property ($fell(o_sda_oe_b) |-> !i_scl)
      else $error("data drive began with clock high");
   a_wake_pulse: assert property (o_wake |=> !o_wake)
      else $error("wake pulse too long");
endmodule
bind i2css_top i2css_assertions #(.ADDR_W(ADDR_W)) i2css_assertions_i (.i_clock(i_clock),
   .i_rst_b(i_rst_b), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_scl(i_scl), .o_sda_oe_b(o_sda_oe_b),
   .o_wake(o_wake), .o_irq(o_irq));

/* tb/i2css_master_model.sv */
// Behavioural I2C bus master that makes the clock and pulls the data line.
module i2css_master_model (
   output logic o_scl,
   output logic o_sda_low,
   input wire logic i_sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // ==========================================================================
   // Framing: the data line moves while the clock is high only here.
   // The offset keeps every line change away from the block's sampling edges.
   task automatic start();
      #10;
      o_sda_low = 1'b1;
      #100 o_scl = 1'b0;
      #100;
   endtask
   task automatic stop();
      o_sda_low = 1'b1;
      #100 o_scl = 1'b1;
      #100 o_sda_low = 1'b0;
      #400;
   endtask
   // ==========================================================================
   // One 400 ns bit, long low phase: the slave moves its drive some 250 ns after the fall.
   task automatic bit_io(input logic b, output logic s);
      #100 o_sda_low = !b;
      #200 o_scl = 1'b1;
      #50 s = i_sda;
      #50 o_scl = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(1'b1, ack);
      #200;
   endtask
endmodule

/* tb/i2css_top_bench.sv */
// Self-checking bench for the I2C slave status flag block.
`include "i2css_consts.vh"
module i2css_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] r_sts = `I2CSS_IDX_STATUS;
   localparam logic [15:0] r_clr = `I2CSS_IDX_CLEAR;
   localparam logic [15:0] r_mode = `I2CSS_IDX_MODE;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic [17:0] adr = 18'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0] ben = 4'h0;
   logic stby = 1'b0;
   logic [7:0] txd = 8'hff;
   logic [31:0] rdata;
   logic [7:0] rxb, mrx;
   logic wreq, scl, sda_low, sda_out, sda_oe_b, wake, irq, ka, kd;
   logic [15:0] q;
   int n_errors = 0;
   int total_checks = 0;
   int wakes = 0;
   // The line has a pull-up: it is low only where some party pulls it.
   wire sda = !(sda_low || (!sda_oe_b && !sda_out));
   always #25 i_clock = !i_clock;
   always @(negedge i_clock) if (wake === 1'b1) wakes++;
   i2css_top #(.ADDR_W(18)) i2css_top_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(ben), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_b(sda_oe_b), .i_deep_standby(stby),
      .i_tx_data(txd), .o_rx_byte(rxb), .o_wake(wake), .o_irq(irq));
   i2css_master_model i2css_master_model_i (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   // ==========================================================================
   // Shared tasks
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Waitrequest and read data are taken at the rising edge that finds waitrequest low.
   task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge i_clock);
      adr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= {16'h0, d};
      ben <= be;
      do begin
         @(posedge i_clock);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata[15:0];
      if (wreq !== 1'b0) begin
         chk(16'h1, 16'h0);
         end_sim();
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wrr(input logic [15:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d, 4'h3);
   endtask
   task automatic rdm(input logic [15:0] idx, input logic [15:0] m, input logic [15:0] e);
      bus(1'b0, idx, 16'h0, 4'h3);
      chk(q & m, e);
   endtask
   task automatic xfer(input logic [7:0] a, input logic [7:0] d);
      i2css_master_model_i.start();
      i2css_master_model_i.byte_io(a, mrx, ka);
      i2css_master_model_i.byte_io(d, mrx, kd);
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      rdm(r_sts, 16'hffff, 16'h0);
      rdm(r_clr, 16'hffff, 16'h0);
      rdm(16'h0100, 16'hffff, 16'h0);
      wrr(r_sts, 16'hffff);
      rdm(r_sts, 16'hffff, 16'h0);
      rdm(r_mode, 16'hffff, 16'h0);
      $display("test reset done");
   endtask
   task automatic t_write();
      wrr(`I2CSS_IDX_OWN_ADDR, 16'h00a0);
      wrr(`I2CSS_IDX_IRQ_MASK, 16'h0400);
      wrr(r_mode, 16'h0061);
      xfer(8'ha0, 8'h3c);
      chk({15'h0, ka}, 16'h0);
      chk({8'h0, rxb}, 16'h003c);
      chk({15'h0, irq}, 16'h0);
      i2css_master_model_i.stop();
      rdm(r_sts, 16'hffff, 16'h0f08);
      chk({15'h0, irq}, 16'h1);
      rdm(`I2CSS_IDX_IRQ_STAT, 16'h0400, 16'h0400);
      repeat (3) @(negedge i_clock);
      chk({15'h0, irq}, 16'h0);
      // Mode bits 4 and 2 do not gate clear writes; this lane 0 clear drops the addressed flag.
      bus(1'b1, r_clr, 16'hffff, 4'h1);
      rdm(r_sts, 16'hffff, 16'h0f00);
      bus(1'b1, r_clr, 16'hffff, 4'h2);
      rdm(r_sts, 16'hffff, 16'h0);
      $display("test write done");
   endtask
   task automatic t_read();
      xfer(8'ha1, 8'h7f);
      chk({8'h0, mrx}, 16'h007f);
      rdm(r_sts, 16'hffff, 16'h0b1e);
      i2css_master_model_i.stop();
      rdm(r_sts, 16'hffff, 16'h0f0e);
      wrr(r_clr, 16'h0002);
      rdm(r_sts, 16'hffff, 16'h0f0c);
      wrr(r_mode, 16'h0000);
      rdm(r_sts, 16'hffff, 16'h0);
      $display("test read done");
   endtask
   task automatic t_foreign();
      wrr(r_mode, 16'h0001);
      xfer(8'h42, 8'hff);
      i2css_master_model_i.stop();
      chk({15'h0, ka}, 16'h1);
      rdm(r_sts, 16'hfffd, 16'h0);
      wrr(r_mode, 16'h0061);
      xfer(8'h42, 8'hff);
      i2css_master_model_i.stop();
      rdm(r_sts, 16'hfffd, 16'h1c00);
      wrr(r_clr, 16'h1c02);
      $display("test foreign done");
   endtask
   task automatic t_wake();
      wrr(r_mode, 16'h0001);
      stby <= 1'b1;
      xfer(8'ha0, 8'h00);
      i2css_master_model_i.stop();
      chk({15'h0, ka}, 16'h1);
      rdm(r_sts, 16'h2208, 16'h2000);
      chk(wakes[15:0], 16'h1);
      wrr(r_clr, 16'h2000);
      rdm(r_sts, 16'h2000, 16'h0);
      stby <= 1'b0;
      $display("test wake done");
   endtask
   initial begin
      repeat (4) @(posedge i_clock);
      i_rst_b <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_foreign();
      t_wake();
      end_sim();
   end
endmodule

/* verilog/i2css_consts.vh */
// Constants for the I2C slave status flag block: register map, field positions, codes.
`ifndef I2CSS_CONSTS_VH
`define I2CSS_CONSTS_VH
// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define I2CSS_IDX_OWN_ADDR 16'hf784
`define I2CSS_IDX_MODE 16'hf78a
`define I2CSS_IDX_STATUS 16'hf78c
`define I2CSS_IDX_CLEAR 16'hf78e
`define I2CSS_IDX_IRQ_STAT 16'hf790
`define I2CSS_IDX_IRQ_MASK 16'hf792
// ==========================================================================
// Status and clear bit positions (shared layout).
`define I2CSS_B_WAKE_NACK 13
`define I2CSS_B_FOREIGN 12
`define I2CSS_B_START 11
`define I2CSS_B_STOP 10
`define I2CSS_B_DATA_DONE 9
`define I2CSS_B_ADDR_DONE 8
`define I2CSS_B_DIRECTION 4
`define I2CSS_B_ADDRESSED 3
`define I2CSS_B_BIT_ERROR 2
`define I2CSS_B_RX_ACK 1
`define I2CSS_FLAG_MASK 16'h3f1e
`define I2CSS_RESET_16 16'h0000
// ==========================================================================
// Mode register fields.
`define I2CSS_M_ENABLE 0
`define I2CSS_M_SELF_ONLY 2
`define I2CSS_M_RESTART_OTHER 4
`define I2CSS_M_STOP_IRQ 5
`define I2CSS_M_START_IRQ 6
`define I2CSS_MODE_MASK 8'h75
// ==========================================================================
// Link state codes and bit counts.
`define I2CSS_ST_IDLE 2'h0
`define I2CSS_ST_ADDR 2'h1
`define I2CSS_ST_DATA 2'h2
`define I2CSS_ST_SKIP 2'h3
`define I2CSS_CNT_ACK 4'h8
`define I2CSS_CNT_END 4'h9
`define I2CSS_CNT_ZERO 4'h0
`endif

/* verilog/i2css_top.v */
// I2C slave status flags, clear register, slave byte engine and Avalon-MM register slave.
`include "i2css_consts.vh"

module i2css_top #(
   parameter ADDR_W = 18
) (
   input wire i_clock,
   input wire i_rst_b,
   input wire [ADDR_W-1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output wire [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   input wire i_scl,
   input wire i_sda,
   output wire o_sda_out,
   output wire o_sda_oe_b,
   input wire i_deep_standby,
   input wire [7:0] i_tx_data,
   output wire [7:0] o_rx_byte,
   output wire o_wake,
   output wire o_irq
);

   // ==========================================================================
   // Helpers.
   function hit;
      input [ADDR_W-1:0] addr;
      input [15:0] idx;
      begin
         hit = (addr[ADDR_W-1:2] == idx);
      end
   endfunction

   function [15:0] lanes;
      input [3:0] be;
      begin
         lanes = {{8{be[1]}}, {8{be[0]}}};
      end
   endfunction

   // ==========================================================================
   // Bus slave: one wait cycle, then waitrequest low for exactly one cycle.
   reg wait_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   reg [15:0] flag_q;
   reg [15:0] flag_d;
   reg [15:0] irq_stat_q;
   reg [15:0] irq_stat_d;
   reg [15:0] irq_mask_q;
   reg [7:0] mode_q;
   reg [6:0] own_addr_q;
   reg irq_q;
   wire req = i_avs_read | i_avs_write;
   wire commit = req & ~wait_q;
   wire wr = commit & i_avs_write;
   wire [15:0] wmask = i_avs_writedata[15:0] & lanes(i_avs_byteenable);
   wire en = mode_q[`I2CSS_M_ENABLE];
   wire start_en = mode_q[`I2CSS_M_START_IRQ];
   wire stop_en = mode_q[`I2CSS_M_STOP_IRQ];
   // Of bus writes, only clear writes and a mode write that drops the enable touch the flags; a write to the status index is dropped.
   // Byte lanes that are not enabled clear nothing, so a byte write spares the other half.
   wire [15:0] sw_clr = wr_to(`I2CSS_IDX_CLEAR) ? wmask : `I2CSS_RESET_16;
   wire irq_rd_clr = commit & i_avs_read & hit(i_avs_address, `I2CSS_IDX_IRQ_STAT);

   // A write lands only at the edge that commits it, never in the wait cycle.
   function wr_to;
      input [15:0] idx;
      begin
         wr_to = wr && hit(i_avs_address, idx);
      end
   endfunction

   always @* begin
      rdata_d = 32'h0000_0000;
      if (i_avs_read && wait_q) begin
         if (hit(i_avs_address, `I2CSS_IDX_STATUS))
            rdata_d = {16'h0000, flag_q};
         else if (hit(i_avs_address, `I2CSS_IDX_MODE))
            rdata_d = {24'h00_0000, mode_q};
         else if (hit(i_avs_address, `I2CSS_IDX_OWN_ADDR))
            rdata_d = {24'h00_0000, own_addr_q, 1'b0};
         else if (hit(i_avs_address, `I2CSS_IDX_IRQ_STAT))
            rdata_d = {16'h0000, irq_stat_q};
         else if (hit(i_avs_address, `I2CSS_IDX_IRQ_MASK))
            rdata_d = {16'h0000, irq_mask_q};
      end
   end

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         mode_q <= 8'h00;
         own_addr_q <= 7'h00;
         irq_mask_q <= `I2CSS_RESET_16;
      end else begin
         wait_q <= ~(req & wait_q);
         rdata_q <= rdata_d;
         // Reserved mode bits are masked so that they always read back as zero.
         if (wr_to(`I2CSS_IDX_MODE) && i_avs_byteenable[0])
            mode_q <= i_avs_writedata[7:0] & `I2CSS_MODE_MASK;
         if (wr_to(`I2CSS_IDX_OWN_ADDR) && i_avs_byteenable[0])
            own_addr_q <= i_avs_writedata[7:1];
         if (wr_to(`I2CSS_IDX_IRQ_MASK))
            irq_mask_q <= (irq_mask_q & ~lanes(i_avs_byteenable)) | (wmask & `I2CSS_FLAG_MASK);
      end
   end

   // ==========================================================================
   // Pin synchronisers: three stages, a level counts once stages two and three agree.
   // The price is some four clocks of latency on every line edge. A master must
   // hold the link clock low for more than five system clocks, or the slave would
   // move its data drive while the clock is already high again.
   reg [2:0] scl_sync_q;
   reg [2:0] sda_sync_q;
   reg scl_q;
   reg sda_q;
   reg scl_prev_q;
   reg sda_prev_q;

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], i_scl};
         sda_sync_q <= {sda_sync_q[1:0], i_sda};
         if (scl_sync_q[1] == scl_sync_q[2])
            scl_q <= scl_sync_q[2];
         if (sda_sync_q[1] == sda_sync_q[2])
            sda_q <= sda_sync_q[2];
         scl_prev_q <= scl_q;
         sda_prev_q <= sda_q;
      end
   end

   wire scl_rise = scl_q & ~scl_prev_q;
   wire scl_fall = ~scl_q & scl_prev_q;
   wire start_ev = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
   wire stop_ev = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

   // ==========================================================================
   // Slave byte engine. Events are registered pulses that feed the flags next cycle.
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg [7:0] shift_q;
   reg [7:0] shift_d;
   reg [7:0] tx_q;
   reg [7:0] tx_d;
   reg rw_q;
   reg rw_d;
   reg drive_q;
   reg drive_d;
   reg err_hold_q;
   reg err_hold_d;
   reg [7:0] rx_q;
   reg [7:0] rx_d;
   reg wake_q;
   reg wake_d;
   reg [15:0] set_q;
   reg [15:0] set_d;
   reg [15:0] hwclr_q;
   reg [15:0] hwclr_d;
   wire match = (shift_q[7:1] == own_addr_q);

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      tx_d = tx_q;
      rw_d = rw_q;
      drive_d = drive_q;
      err_hold_d = err_hold_q;
      rx_d = rx_q;
      wake_d = 1'b0;
      set_d = `I2CSS_RESET_16;
      hwclr_d = `I2CSS_RESET_16;
      if (!en) begin
         state_d = `I2CSS_ST_IDLE;
         drive_d = 1'b0;
         err_hold_d = 1'b0;
      end else if (start_ev) begin
         state_d = `I2CSS_ST_ADDR;
         cnt_d = `I2CSS_CNT_ZERO;
         drive_d = 1'b0;
         err_hold_d = 1'b0;
         set_d[`I2CSS_B_START] = start_en;
      end else if (stop_ev) begin
         state_d = `I2CSS_ST_IDLE;
         drive_d = 1'b0;
         err_hold_d = 1'b0;
         set_d[`I2CSS_B_STOP] = stop_en;
         hwclr_d[`I2CSS_B_DIRECTION] = 1'b1;
      end else if (state_q == `I2CSS_ST_ADDR || state_q == `I2CSS_ST_DATA) begin
         if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q < `I2CSS_CNT_ACK) begin
               shift_d = {shift_q[6:0], sda_q};
               if (state_q == `I2CSS_ST_DATA && rw_q && !err_hold_q && sda_q != tx_q[7]) begin
                  set_d[`I2CSS_B_BIT_ERROR] = 1'b1;
                  err_hold_d = 1'b1;
                  drive_d = 1'b0;
               end
            end else begin
               // Acknowledge slot sampled on the rising clock.
               set_d[`I2CSS_B_RX_ACK] = sda_q;
               hwclr_d[`I2CSS_B_RX_ACK] = ~sda_q;
               if (state_q == `I2CSS_ST_DATA) begin
                  set_d[`I2CSS_B_DATA_DONE] = 1'b1;
                  if (!rw_q)
                     rx_d = shift_q;
                  else if (sda_q)
                     state_d = `I2CSS_ST_SKIP;
               end
            end
         end else if (scl_fall) begin
            if (cnt_q == `I2CSS_CNT_ACK) begin
               if (state_q == `I2CSS_ST_ADDR) begin
                  if (match && i_deep_standby) begin
                     // Woken by our address: nack stays on the line, no data flags.
                     set_d[`I2CSS_B_WAKE_NACK] = 1'b1;
                     wake_d = 1'b1;
                     drive_d = 1'b0;
                     state_d = `I2CSS_ST_SKIP;
                  end else if (match) begin
                     set_d[`I2CSS_B_ADDR_DONE] = 1'b1;
                     set_d[`I2CSS_B_ADDRESSED] = 1'b1;
                     set_d[`I2CSS_B_DIRECTION] = shift_q[0];
                     hwclr_d[`I2CSS_B_DIRECTION] = ~shift_q[0];
                     rw_d = shift_q[0];
                     drive_d = 1'b1;
                  end else begin
                     set_d[`I2CSS_B_FOREIGN] = start_en;
                     state_d = `I2CSS_ST_SKIP;
                  end
               end else begin
                  drive_d = ~rw_q;
               end
            end else if (cnt_q == `I2CSS_CNT_END) begin
               // Byte over: any error hold lapses and the next byte starts.
               cnt_d = `I2CSS_CNT_ZERO;
               state_d = `I2CSS_ST_DATA;
               err_hold_d = 1'b0;
               tx_d = i_tx_data;
               drive_d = rw_q & ~i_tx_data[7];
            end else if (state_q == `I2CSS_ST_DATA && rw_q) begin
               tx_d = {tx_q[6:0], 1'b0};
               drive_d = ~tx_q[6] & ~err_hold_q;
            end
         end
      end
   end

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         state_q <= `I2CSS_ST_IDLE;
         cnt_q <= `I2CSS_CNT_ZERO;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         drive_q <= 1'b0;
         err_hold_q <= 1'b0;
         rx_q <= 8'h00;
         wake_q <= 1'b0;
         set_q <= `I2CSS_RESET_16;
         hwclr_q <= `I2CSS_RESET_16;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         rw_q <= rw_d;
         drive_q <= drive_d;
         err_hold_q <= err_hold_d;
         rx_q <= rx_d;
         wake_q <= wake_d;
         set_q <= set_d;
         hwclr_q <= hwclr_d;
      end
   end

   // ==========================================================================
   // Flags and interrupt. A set in the same cycle as a clear wins.
   // Losing a set to a clear would hide a whole bus event from software, while a
   // flag that survives a clear costs only one more read.
   reg sda_out_q;

   always @* begin
      if (!en)
         flag_d = `I2CSS_RESET_16;
      else
         flag_d = ((flag_q & ~sw_clr & ~hwclr_q) | set_q) & `I2CSS_FLAG_MASK;
      irq_stat_d = ((irq_stat_q & ~{16{irq_rd_clr}}) | set_q) & `I2CSS_FLAG_MASK;
   end

   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         flag_q <= `I2CSS_RESET_16;
         irq_stat_q <= `I2CSS_RESET_16;
         irq_q <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         // The pin is open drain: it only ever pulls low, so the level stays low.
         sda_out_q <= 1'b0;
         flag_q <= flag_d;
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   // The engine's drive_q decides whether the line is pulled; a cleared enable only forces it off.
   assign o_sda_out = sda_out_q;
   assign o_sda_oe_b = ~drive_q;
   assign o_rx_byte = rx_q;
   assign o_wake = wake_q;
   assign o_irq = irq_q;

endmodule
